// *** shared/strap_cfg_pkg.sv ***
// Behaviour
// - Endian strap picks byte order, little default
// - Boot strap: none, host port, 8-bit ROM
// - Clock strap: pin, CPU/4, CPU/6, reserved
// - Width strap picks 16 or 32 bit host
// - Wide host without Ethernet uses all pins
// - Narrow host without Ethernet floats upper pins
// - Ethernet strap low keeps Ethernet disabled
// - Ethernet high, narrow: upper pins to Ethernet
// - Both high: host off, lower float
// - Host/Ethernet choice made only by straps
// - Timers drive their pins once straps freeze; serial and video2 enables follow the selection register
// - Latch all configuration straps just after reset release
// - Software selects peripherals via selection register
// - Three registers in one 4K block
// - CPU reaches registers only via config bus
// - Selection register enables video, serial, audio, I2C
package strap_cfg_pkg;

  // Strap vector layout after synchronising
  localparam int STRAP_W = 8;
  localparam int STRAP_CLK_LSB = 0;
  localparam int STRAP_BOOT_LSB = 2;
  localparam int STRAP_ENDIAN = 4;
  localparam int STRAP_WIDTH = 5;
  localparam int STRAP_ETH = 6;
  localparam int STRAP_GPIO0 = 7;
  localparam int SYNC_STAGES = 3;

  // Configuration block
  localparam logic [31:0] CFG_BASE = 32'h01b3f000;
  localparam logic [11:0] OFS_PERIPH_SEL = 12'h000;
  localparam logic [11:0] OFS_DEV_STATUS = 12'h004;
  localparam logic [11:0] OFS_IDENT = 12'h008;
  localparam logic [31:0] IDENT_VALUE = 32'h0a5a0001;

  // Peripheral selection fields
  localparam int SEL_AUDIO0 = 0;
  localparam int SEL_BSP0 = 1;
  localparam int SEL_BSP1 = 2;
  localparam int SEL_TWO_WIRE0 = 3;
  localparam int SEL_VIDEO1 = 5;
  localparam int SEL_VIDEO2 = 6;
  localparam logic [31:0] SEL_WMASK = 32'h0000006f;
  localparam logic [31:0] SEL_RESET = 32'h00000006;

  // Device status fields
  localparam int STAT_VALID = 8;

  // Decoded strap codes
  localparam logic [1:0] BOOT_NONE = 2'h0;
  localparam logic [1:0] BOOT_HOST = 2'h1;
  localparam logic [1:0] BOOT_RSVD = 2'h2;
  localparam logic [1:0] BOOT_ROM8 = 2'h3;
  localparam logic [1:0] ECLK_PIN = 2'h0;
  localparam logic [1:0] ECLK_DIV4 = 2'h1;
  localparam logic [1:0] ECLK_DIV6 = 2'h2;
  localparam logic [1:0] ECLK_RSVD = 2'h3;
  localparam logic BYTE_ORDER_LITTLE = 1'b1;

  typedef enum logic [1:0] {
    ST_FILL = 2'b00,
    ST_CHECK = 2'b01,
    ST_FROZEN = 2'b11
  } cap_state_t;

endpackage

// *** core/reset_strap_peripheral_select.sv ***
`timescale 1ns/1ps
module reset_strap_peripheral_select #(
  parameter logic [31:0] IDENT = strap_cfg_pkg::IDENT_VALUE
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Strap pins
  input wire logic [3:0] i_strap_address_pins,
  input wire logic i_endian_strap,
  input wire logic i_host_width_strap,
  input wire logic i_ethernet_select_strap,
  input wire logic i_gpio_bit0_strap,
  // Timer outputs sharing strap pins
  input wire logic i_timer0_out,
  input wire logic i_timer1_out,
  output logic o_timer0_output_pin_o,
  output logic o_timer0_output_pin_oe,
  output logic o_timer1_output_pin_o,
  output logic o_timer1_output_pin_oe,
  // Config bus
  input wire logic i_cfg_req,
  input wire logic i_cfg_wr,
  input wire logic [31:0] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  // Decoded configuration
  output logic o_strap_valid,
  output logic o_byte_order_mode,
  output logic [1:0] o_boot_mode,
  output logic [1:0] o_ext_mem_clock_select,
  output logic o_host_port_enable,
  output logic o_host_port_wide,
  output logic o_ethernet_enable,
  output logic o_config_invalid,
  // Peripheral enables
  output logic o_video_port_first_en,
  output logic o_video_port_second_en,
  output logic o_buffered_serial_port_first_en,
  output logic o_audio_serial_port_first_en,
  output logic o_two_wire_controller_first_en,
  // Host port and Ethernet cores
  input wire logic [31:0] i_host_port_o,
  input wire logic [31:0] i_host_port_oe,
  output logic [31:0] o_host_port_i,
  input wire logic [15:0] i_ethernet_o,
  input wire logic [15:0] i_ethernet_oe,
  output logic [15:0] o_ethernet_i,
  // Host data pins
  input wire logic [31:0] i_host_data_pin,
  output logic [31:0] o_host_data_pin_o,
  output logic [31:0] o_host_data_pin_oe
);
  import strap_cfg_pkg::*;

  logic [STRAP_W-1:0] strap_pins;
  logic [STRAP_W-1:0] sync1_q;
  logic [STRAP_W-1:0] sync2_q;
  logic [STRAP_W-1:0] sync3_q;
  logic [STRAP_W-1:0] cap_q;
  logic [1:0] fill_q;
  cap_state_t state_q;
  cap_state_t state_d;
  logic [31:0] sel_q;
  logic wide;
  logic eth;
  logic host_low_own;
  logic host_up_own;
  logic eth_up_own;
  logic in_block;
  logic [11:0] ofs;

  assign strap_pins = {i_gpio_bit0_strap, i_ethernet_select_strap, i_host_width_strap,
                       i_endian_strap, i_strap_address_pins};

  // Straps are static pins; three stages keep metastability off the capture
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end
    else
    begin
      sync1_q <= strap_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Capture cannot happen under async reset, so it happens just after release
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_FILL:
        if (fill_q == 2'(SYNC_STAGES - 1))
          state_d = ST_CHECK;
      ST_CHECK:
        if (sync2_q == sync3_q)
          state_d = ST_FROZEN;
      ST_FROZEN:
        state_d = ST_FROZEN;
      default:
        state_d = ST_FILL;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= ST_FILL;
      fill_q <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_FILL)
        fill_q <= fill_q + 2'h1;
    end
  end

  // Only a reset reopens the capture; later strap pin changes are ignored
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cap_q <= '0;
    else if (state_q == ST_CHECK && state_d == ST_FROZEN)
      cap_q <= sync3_q;
  end

  assign wide = cap_q[STRAP_WIDTH];
  assign eth = cap_q[STRAP_ETH];
  assign host_low_own = !(wide && eth);
  assign host_up_own = wide && !eth;
  assign eth_up_own = eth;

  // Decoded configuration; defaults stand until capture completes
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_strap_valid <= 1'b0;
      o_byte_order_mode <= BYTE_ORDER_LITTLE;
      o_boot_mode <= BOOT_NONE;
      o_ext_mem_clock_select <= ECLK_PIN;
      o_host_port_enable <= 1'b0;
      o_host_port_wide <= 1'b0;
      o_ethernet_enable <= 1'b0;
      o_config_invalid <= 1'b0;
    end
    else if (state_q == ST_FROZEN)
    begin
      o_strap_valid <= 1'b1;
      o_byte_order_mode <= cap_q[STRAP_ENDIAN];
      o_boot_mode <= cap_q[STRAP_BOOT_LSB +: 2];
      o_ext_mem_clock_select <= cap_q[STRAP_CLK_LSB +: 2];
      o_host_port_enable <= host_low_own;
      o_host_port_wide <= wide && !eth;
      o_ethernet_enable <= eth;
      // Board must hold gpio bit zero low; reserved codes are flagged too
      o_config_invalid <= cap_q[STRAP_GPIO0]
                          || cap_q[STRAP_BOOT_LSB +: 2] == BOOT_RSVD
                          || cap_q[STRAP_CLK_LSB +: 2] == ECLK_RSVD;
    end
  end

  // Host data pins: straps alone pick the owner of each pin group
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_pin
      logic host_own;
      logic eth_own;
      logic eth_pin_o;
      logic eth_pin_oe;
      // Lower pins never reach the Ethernet core, so no index below zero is formed
      if (g < 16)
      begin : g_low
        assign host_own = host_low_own;
        assign eth_own = 1'b0;
        assign eth_pin_o = 1'b0;
        assign eth_pin_oe = 1'b0;
      end
      else
      begin : g_up
        assign host_own = host_up_own;
        assign eth_own = eth_up_own;
        assign eth_pin_o = i_ethernet_o[g-16];
        assign eth_pin_oe = i_ethernet_oe[g-16];
      end
      always_ff @(posedge i_sys_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          o_host_data_pin_o[g] <= 1'b0;
          o_host_data_pin_oe[g] <= 1'b0;
          o_host_port_i[g] <= 1'b0;
        end
        else if (state_q != ST_FROZEN)
        begin
          o_host_data_pin_o[g] <= 1'b0;
          o_host_data_pin_oe[g] <= 1'b0;
          o_host_port_i[g] <= 1'b0;
        end
        else if (host_own)
        begin
          o_host_data_pin_o[g] <= i_host_port_o[g];
          o_host_data_pin_oe[g] <= i_host_port_oe[g];
          o_host_port_i[g] <= i_host_data_pin[g];
        end
        else if (eth_own)
        begin
          o_host_data_pin_o[g] <= eth_pin_o;
          o_host_data_pin_oe[g] <= eth_pin_oe;
          o_host_port_i[g] <= 1'b0;
        end
        else
        begin
          o_host_data_pin_o[g] <= 1'b0;
          o_host_data_pin_oe[g] <= 1'b0;
          o_host_port_i[g] <= 1'b0;
        end
      end
      if (g >= 16)
      begin : g_eth_in
        always_ff @(posedge i_sys_clk or negedge i_rst_n)
        begin
          if (!i_rst_n)
            o_ethernet_i[g-16] <= 1'b0;
          else
            o_ethernet_i[g-16] <= (state_q == ST_FROZEN && eth_own) ? i_host_data_pin[g] : 1'b0;
        end
      end
    end
  endgenerate

  // Timer pins are strap inputs during reset and only driven once frozen
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_timer0_output_pin_o <= 1'b0;
      o_timer0_output_pin_oe <= 1'b0;
      o_timer1_output_pin_o <= 1'b0;
      o_timer1_output_pin_oe <= 1'b0;
    end
    else
    begin
      o_timer0_output_pin_o <= i_timer0_out;
      o_timer0_output_pin_oe <= state_q == ST_FROZEN;
      o_timer1_output_pin_o <= i_timer1_out;
      o_timer1_output_pin_oe <= state_q == ST_FROZEN;
    end
  end

  // Config bus decode over the 4K block
  assign in_block = i_cfg_addr[31:12] == CFG_BASE[31:12];
  assign ofs = i_cfg_addr[11:0];

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sel_q <= SEL_RESET;
    else if (i_cfg_req && i_cfg_wr && in_block && ofs == OFS_PERIPH_SEL)
      sel_q <= i_cfg_wdata & SEL_WMASK;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cfg_ack <= 1'b0;
      o_cfg_rdata <= 32'h0;
    end
    else
    begin
      o_cfg_ack <= i_cfg_req && in_block;
      o_cfg_rdata <= 32'h0;
      if (i_cfg_req && !i_cfg_wr && in_block)
        case (ofs)
          OFS_PERIPH_SEL: o_cfg_rdata <= sel_q;
          OFS_DEV_STATUS: o_cfg_rdata <= {23'h0, o_strap_valid, cap_q};
          OFS_IDENT: o_cfg_rdata <= IDENT; // Arbitrary value, names no part
          default: o_cfg_rdata <= 32'h0;
        endcase
    end
  end

  // Enables follow the register with one flop of delay
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_video_port_first_en <= 1'b0;
      o_video_port_second_en <= 1'b0;
      o_buffered_serial_port_first_en <= 1'b0;
      o_audio_serial_port_first_en <= 1'b0;
      o_two_wire_controller_first_en <= 1'b0;
    end
    else
    begin
      o_video_port_first_en <= sel_q[SEL_VIDEO1];
      o_video_port_second_en <= sel_q[SEL_VIDEO2];
      o_buffered_serial_port_first_en <= sel_q[SEL_BSP0];
      o_audio_serial_port_first_en <= sel_q[SEL_AUDIO0];
      o_two_wire_controller_first_en <= sel_q[SEL_TWO_WIRE0];
    end
  end

  // Checks
  sequence s_sel_write;
    i_cfg_req && i_cfg_wr && in_block && ofs == OFS_PERIPH_SEL;
  endsequence
  sequence s_frozen;
    state_q == ST_FROZEN && o_strap_valid;
  endsequence

  property p_endian;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_frozen |-> o_byte_order_mode == cap_q[STRAP_ENDIAN];
  endproperty
  a_endian: assert property (p_endian) else $error("byte order mismatch");

  property p_boot;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_frozen |-> o_boot_mode == cap_q[3:2];
  endproperty
  a_boot: assert property (p_boot) else $error("boot mode mismatch");

  property p_eclk;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_frozen |-> o_ext_mem_clock_select == cap_q[1:0];
  endproperty
  a_eclk: assert property (p_eclk) else $error("clock select mismatch");

  property p_wide;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_frozen and wide && !eth |=> o_host_data_pin_oe == $past(i_host_port_oe);
  endproperty
  a_wide: assert property (p_wide) else $error("wide host pins wrong");

  property p_narrow_float;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_frozen and !wide && !eth |=> o_host_data_pin_oe[31:16] == 16'h0;
  endproperty
  a_narrow_float: assert property (p_narrow_float) else $error("upper pins driven");

  property p_eth_off;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_frozen and !eth |=> !o_ethernet_enable && o_ethernet_i == 16'h0;
  endproperty
  a_eth_off: assert property (p_eth_off) else $error("ethernet active");

  property p_eth_upper;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_frozen and eth |=> o_host_data_pin_o[31:16] == $past(i_ethernet_o);
  endproperty
  a_eth_upper: assert property (p_eth_upper) else $error("upper pins not ethernet");

  property p_both_float;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_frozen and wide && eth |=> o_host_data_pin_oe[15:0] == 16'h0 && !o_host_port_enable;
  endproperty
  a_both_float: assert property (p_both_float) else $error("lower pins driven");

  property p_frozen;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_frozen |=> $stable(cap_q) && state_q == ST_FROZEN;
  endproperty
  a_frozen: assert property (p_frozen) else $error("straps changed");

  property p_sel_write;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_sel_write |=> ##1 o_video_port_second_en == $past(i_cfg_wdata[SEL_VIDEO2], 2);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("enable not updated");

  property p_ack;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cfg_req && !in_block |=> !o_cfg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack outside block");

  property p_capture_time;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    state_q == ST_FILL ##1 state_q == ST_FILL ##1 state_q == ST_CHECK |-> !o_strap_valid;
  endproperty
  a_capture_time: assert property (p_capture_time) else $error("valid too early");

endmodule

// *** sim/strap_board_model.sv ***
`timescale 1ns/1ps
module strap_board_model (
  // Resistor levels and bus activity
  input wire logic [7:0] i_pull,
  input wire logic i_bus_drive,
  // Timer drive on shared pins
  input wire logic i_t0_o,
  input wire logic i_t0_oe,
  input wire logic i_t1_o,
  input wire logic i_t1_oe,
  // Strap pins
  output logic [3:0] o_addr,
  output logic o_endian,
  output logic o_width,
  output logic o_eth,
  output logic o_gpio0
);
  // Once the memory and host buses run, the pulls no longer show
  assign o_addr = i_bus_drive ? ~i_pull[3:0] : i_pull[3:0];
  assign o_width = i_bus_drive ? ~i_pull[5] : i_pull[5];
  // Timer wins over the pull as soon as it drives
  assign o_endian = i_t1_oe ? i_t1_o : i_pull[4];
  assign o_eth = i_t0_oe ? i_t0_o : i_pull[6];
  // Kept low unless the bench asks for a broken board
  assign o_gpio0 = i_pull[7];
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import strap_cfg_pkg::*;
  // Arbitrary identification value
  localparam logic [31:0] ID = 32'h00c0ffee;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] pull = 8'h10;
  logic drv = 1'b0;
  logic t0 = 1'b0;
  logic t1 = 1'b0;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] hp_o = 32'ha5a5c3c3;
  logic [31:0] hp_oe = 32'hffffffff;
  logic [15:0] eth_o = 16'h1234;
  logic [15:0] eth_oe = 16'hffff;
  logic [31:0] ext = 32'h5a5a0f0f;
  logic [3:0] s_addr;
  logic s_end, s_wid, s_eth, s_gp;
  logic t0_o, t0_oe, t1_o, t1_oe;
  logic ack;
  logic [31:0] rdata, pin, pin_o, pin_oe, hp_i;
  logic [15:0] eth_i;
  logic st_valid, bo, host_en, wide, eth_en, inval;
  logic [1:0] boot, eclk;
  logic vid1, vid2, bsp, aud, i2c;
  int err_total = 0;
  int n_tests = 0;
  logic [7:0] cfgs [5] = '{8'h10, 8'h25, 8'h5e, 8'h6b, 8'h90};
  logic [31:0] wv [7] = '{32'h1, 32'h2, 32'h8, 32'h20, 32'h40, 32'hffffffff, 32'h0};

  always #10 clk = ~clk;
  assign pin = (pin_oe & pin_o) | (~pin_oe & ext);

  strap_board_model strap_board_model_inst (.i_pull(pull), .i_bus_drive(drv),
    .i_t0_o(t0_o), .i_t0_oe(t0_oe), .i_t1_o(t1_o), .i_t1_oe(t1_oe), .o_addr(s_addr),
    .o_endian(s_end), .o_width(s_wid), .o_eth(s_eth), .o_gpio0(s_gp));

  reset_strap_peripheral_select #(.IDENT(ID)) reset_strap_peripheral_select_inst (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_strap_address_pins(s_addr),
    .i_endian_strap(s_end), .i_host_width_strap(s_wid), .i_ethernet_select_strap(s_eth),
    .i_gpio_bit0_strap(s_gp), .i_timer0_out(t0), .i_timer1_out(t1),
    .o_timer0_output_pin_o(t0_o), .o_timer0_output_pin_oe(t0_oe),
    .o_timer1_output_pin_o(t1_o), .o_timer1_output_pin_oe(t1_oe),
    .i_cfg_req(req), .i_cfg_wr(wr), .i_cfg_addr(addr), .i_cfg_wdata(wdata),
    .o_cfg_ack(ack), .o_cfg_rdata(rdata), .o_strap_valid(st_valid),
    .o_byte_order_mode(bo), .o_boot_mode(boot), .o_ext_mem_clock_select(eclk),
    .o_host_port_enable(host_en), .o_host_port_wide(wide), .o_ethernet_enable(eth_en),
    .o_config_invalid(inval), .o_video_port_first_en(vid1), .o_video_port_second_en(vid2),
    .o_buffered_serial_port_first_en(bsp), .o_audio_serial_port_first_en(aud),
    .o_two_wire_controller_first_en(i2c), .i_host_port_o(hp_o), .i_host_port_oe(hp_oe),
    .o_host_port_i(hp_i), .i_ethernet_o(eth_o), .i_ethernet_oe(eth_oe),
    .o_ethernet_i(eth_i), .i_host_data_pin(pin), .o_host_data_pin_o(pin_o),
    .o_host_data_pin_oe(pin_oe));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle request pulse; answer is looked at in its single cycle
  task automatic bus(input logic w, input logic [11:0] ofs, input logic [31:0] d,
                     input logic [31:0] exp);
    @(negedge clk);
    req = 1'b1;
    wr = w;
    addr = {CFG_BASE[31:12], ofs};
    wdata = d;
    @(negedge clk);
    req = 1'b0;
    chk(ack, 1'b1);
    if (!w)
      chk(rdata, exp);
  endtask

  task automatic run_cfg(input logic [7:0] c);
    logic [31:0] eoe;
    eoe = {(c[6] | c[5]) ? 16'hffff : 16'h0, (c[6] & c[5]) ? 16'h0 : 16'hffff};
    pull = c;
    drv = 1'b0;
    t0 = ~c[6];
    t1 = ~c[4];
    hp_oe = 32'hffffffff;
    eth_oe = 16'hffff;
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(pin_oe, 32'h0);
    repeat (6) @(negedge clk);
    // Address and width pins now move away from their strap levels; timers already drive the endian and Ethernet pins
    drv = 1'b1;
    repeat (4) @(negedge clk);
    chk({st_valid, bo, boot, eclk}, {1'b1, c[4:0]});
    chk({host_en, wide, eth_en}, {~(c[6] & c[5]), c[5] & ~c[6], c[6]});
    chk(inval, c[7] | (c[3:2] == 2'h2) | (c[1:0] == 2'h3));
    bus(1'b0, OFS_DEV_STATUS, 32'h0, {23'h0, 1'b1, c});
    chk(pin_oe, eoe);
    chk(pin_o & eoe, {c[6] ? eth_o : hp_o[31:16], hp_o[15:0]} & eoe);
    chk({t0_oe, t1_oe, t0_o, t1_o}, {2'b11, ~c[6], ~c[4]});
    hp_oe = 32'h0;
    eth_oe = 16'h0;
    repeat (3) @(negedge clk);
    chk(hp_i, {eoe[16] && !c[6] ? ext[31:16] : 16'h0, eoe[0] ? ext[15:0] : 16'h0});
    if (c[6])
      chk(eth_i, ext[31:16]);
  endtask

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    foreach (cfgs[k])
      run_cfg(cfgs[k]);
    bus(1'b0, OFS_PERIPH_SEL, 32'h0, 32'h6);
    chk({vid1, vid2, bsp, aud, i2c}, 5'b00100);
    foreach (wv[k])
    begin
      bus(1'b1, OFS_PERIPH_SEL, wv[k], 32'h0);
      @(negedge clk);
      chk({vid1, vid2, bsp, aud, i2c}, {wv[k][5], wv[k][6], wv[k][1], wv[k][0], wv[k][3]});
      bus(1'b0, OFS_PERIPH_SEL, 32'h0, wv[k] & 32'h6f);
    end
    bus(1'b1, OFS_IDENT, 32'h0, 32'h0);
    bus(1'b0, OFS_IDENT, 32'h0, ID);
    bus(1'b0, 12'h100, 32'h0, 32'h0);
    // Address just past the block must get no answer
    @(negedge clk);
    req = 1'b1;
    addr = 32'h01b40000;
    @(negedge clk);
    req = 1'b0;
    chk(ack, 1'b0);
    @(negedge clk);
    chk(ack, 1'b0);
    wrap_up();
  end

  // Whole run is under two hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("ERROR at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule
